// File: rtl/adcsq_top.sv
// Conversion sequencer for a 10-bit successive-approximation converter.
// Assumes an APB master, a comparator output retimed to i_clk,
// and a core that drives i_sleep and the interrupt enable.
// Contract
// - A conversion takes nine bit-periods.
// - Seven clock choices: 2..64 oscillator periods or the RC oscillator.
// - Pair 00/01/10 gives 2/8/32, doubled by halve bit; 11 is RC.
// - Two bit-periods hold-off after each conversion, hold capacitor disconnected.
// - Clearing go mid-conversion aborts; result pair unchanged.
// - After abort wait two bit-periods, then acquisition restarts.
// - First segment after go lasts at most one bit-period.
// - Result loaded justified into 16 bits, unused bits zero.
// - Result bytes are plain read/write registers while disabled.
// - With RC clock, wait one instruction cycle before converting.
// - Completion in sleep clears go, loads result, wakes if enabled.
// - Sleep with non-RC clock aborts and powers down; on bit stays.
// - Reset restores controls, disables, aborts, makes pins analog.
// - Reset leaves the result pair untouched.
// - Port read returns zero for analog pins.
// - Conversion proceeds regardless of pin direction.
// - Align set right-justifies; cleared left-justifies, zeros elsewhere.
// - Completion loads result, clears go, sets done flag.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module adcsq_top (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_rc_osc,
    input  wire logic        i_sleep,
    input  wire logic        i_conv_int_en,
    input  wire logic        i_cmp_hi,
    input  wire logic [4:0]  i_port_pins,
    output logic             o_conv_done_flag,
    output logic             o_wake,
    output logic             o_adc_power,
    output logic             o_hold_connect,
    output logic [9:0]       o_sar_code,
    output logic [2:0]       o_channel_select,
    output logic [4:0]       o_analog_mask,
    output logic [4:0]       o_port_dir,
    output logic             o_busy
);
    adcsq_tad_if tad_bus ();

    adcsq_tad_gen u_tad (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_rc_osc (i_rc_osc),
        .tad      (tad_bus.gen)
    );

    adcsq_pkg::adcsq_state_t state_reg;
    adcsq_pkg::adcsq_state_t state_next;
    logic [1:0] src_pair_reg;
    logic [2:0] chan_reg;
    logic       go_reg;
    logic       on_reg;
    logic       align_reg;
    logic       halve_reg;
    logic [3:0] pcfg_reg;
    logic [4:0] dir_reg;
    logic       done_flag_reg;
    logic       wake_reg;
    logic [9:0] sar_reg;
    logic [3:0] bit_idx_reg;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [3:0] conv_ticks_reg;
    logic [7:0] res_hi_reg;
    logic [7:0] res_lo_reg;
    logic [4:0] pin_s1_reg;
    logic [4:0] pin_s2_reg;
    logic [4:0] pin_s3_reg;
    logic [4:0] pin_lvl_reg;

    // Address match used for every register
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    // Pins that are analog for each port configuration
    function automatic logic [4:0] analog_of(input logic [3:0] cfg);
        case (cfg)
            4'h4, 4'h5: analog_of = 5'h0b;
            4'h6, 4'h7: analog_of = 5'h00;
            4'hd:       analog_of = 5'h0f;
            4'he:       analog_of = 5'h01;
            4'hf:       analog_of = 5'h0d;
            default:    analog_of = 5'h1f;
        endcase
    endfunction : analog_of

    // Bus decode
    wire apb_wr = i_psel & i_penable & i_pwrite;
    wire hit_c0 = hit(i_paddr, adcsq_pkg::ADDR_CTRL0);
    wire hit_c1 = hit(i_paddr, adcsq_pkg::ADDR_CTRL1);
    wire hit_rh = hit(i_paddr, adcsq_pkg::ADDR_RES_HI);
    wire hit_rl = hit(i_paddr, adcsq_pkg::ADDR_RES_LO);
    wire hit_st = hit(i_paddr, adcsq_pkg::ADDR_STAT);
    wire hit_pt = hit(i_paddr, adcsq_pkg::ADDR_PORT);
    wire hit_dr = hit(i_paddr, adcsq_pkg::ADDR_DIR);
    wire mapped = hit_c0 | hit_c1 | hit_rh | hit_rl | hit_st | hit_pt | hit_dr;
    wire wr_c0  = apb_wr & hit_c0;
    wire wr_c1  = apb_wr & hit_c1;
    wire wr_st  = apb_wr & hit_st;
    wire wr_dr  = apb_wr & hit_dr;
    // Result bytes writable only while the converter is off
    wire wr_rh  = apb_wr & hit_rh & ~on_reg;
    wire wr_rl  = apb_wr & hit_rl & ~on_reg;

    // Sequencer conditions
    wire st_off   = (state_reg == adcsq_pkg::ST_OFF);
    wire st_idle  = (state_reg == adcsq_pkg::ST_IDLE);
    wire st_first = (state_reg == adcsq_pkg::ST_FIRST);
    wire st_conv  = (state_reg == adcsq_pkg::ST_CONV);
    wire st_hold  = (state_reg == adcsq_pkg::ST_HOLD);
    wire rc_sel   = (src_pair_reg == adcsq_pkg::RC_PAIR);
    wire tick     = tad_bus.tick;
    wire sleep_kill = i_sleep & ~rc_sel;
    wire powered  = on_reg & ~sleep_kill;
    wire running  = st_first | st_conv;
    wire start    = st_idle & go_reg & powered;
    wire abort    = running & ~go_reg;
    wire first_ok = ~rc_sel | (cnt_reg >= adcsq_pkg::TCY_LAST);
    wire decide   = ((st_first & first_ok) | st_conv) & tick & go_reg & powered;
    wire done     = decide & st_conv & (bit_idx_reg == 4'h0);

    // Successive approximation: keep or drop trial bit, try the next
    wire [9:0] bit_mask = 10'(10'h001 << bit_idx_reg);
    wire [9:0] kept     = i_cmp_hi ? sar_reg : (sar_reg & ~bit_mask);
    wire [9:0] sar_next = kept | (bit_mask >> 1);

    // Justification of the final code into the byte pair
    wire [7:0] just_hi = align_reg ? {6'h00, kept[9:8]} : kept[9:2];
    wire [7:0] just_lo = align_reg ? kept[7:0] : {kept[1:0], 6'h00};

    // Clock choice to the divider
    assign tad_bus.pair    = src_pair_reg;
    assign tad_bus.halve   = halve_reg;
    assign tad_bus.restart = start | abort;

    // Next state
    always_comb begin
        state_next = state_reg;
        if (!powered) begin
            state_next = adcsq_pkg::ST_OFF;
        end else begin
            case (state_reg)
                adcsq_pkg::ST_OFF: begin
                    state_next = adcsq_pkg::ST_IDLE;
                end
                adcsq_pkg::ST_IDLE: begin
                    if (go_reg) begin
                        state_next = adcsq_pkg::ST_FIRST;
                    end
                end
                adcsq_pkg::ST_FIRST: begin
                    if (!go_reg) begin
                        state_next = adcsq_pkg::ST_HOLD;
                    end else if (decide) begin
                        state_next = adcsq_pkg::ST_CONV;
                    end
                end
                adcsq_pkg::ST_CONV: begin
                    if (!go_reg || done) begin
                        state_next = adcsq_pkg::ST_HOLD;
                    end
                end
                adcsq_pkg::ST_HOLD: begin
                    if (tick && cnt_reg == adcsq_pkg::HOLD_LAST) begin
                        state_next = adcsq_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_next = adcsq_pkg::ST_OFF;
                end
            endcase
        end
    end

    // Shared counter: cycles in first segment, ticks in hold-off
    always_comb begin
        cnt_next = cnt_reg;
        if (state_next != state_reg) begin
            cnt_next = 3'h0;
        end else if ((st_first && cnt_reg != 3'h7) || (st_hold && tick)) begin
            cnt_next = cnt_reg + 3'h1;
        end
    end

    // State, counters and trial code
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_reg   <= adcsq_pkg::ST_OFF;
            cnt_reg     <= 3'h0;
            sar_reg     <= 10'h000;
            bit_idx_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            if (start) begin
                sar_reg     <= 10'h200;
                bit_idx_reg <= 4'h9;
            end else if (decide) begin
                sar_reg     <= sar_next;
                bit_idx_reg <= bit_idx_reg - 4'h1;
            end
        end
    end

    // Control registers; hardware clear of go beats a software write
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            {src_pair_reg, chan_reg} <= adcsq_pkg::CTRL0_RST[7:3];
            on_reg    <= adcsq_pkg::CTRL0_RST[adcsq_pkg::ON_BIT];
            go_reg    <= adcsq_pkg::CTRL0_RST[adcsq_pkg::GO_BIT];
            align_reg <= adcsq_pkg::CTRL1_RST[adcsq_pkg::ALIGN_BIT];
            halve_reg <= adcsq_pkg::CTRL1_RST[adcsq_pkg::HALVE_BIT];
            pcfg_reg  <= adcsq_pkg::CTRL1_RST[3:0];
            dir_reg   <= adcsq_pkg::DIR_RST;
        end else begin
            if (wr_c0) begin
                src_pair_reg <= i_pwdata[adcsq_pkg::SRC_LSB +: 2];
                chan_reg     <= i_pwdata[adcsq_pkg::CHAN_LSB +: 3];
                on_reg       <= i_pwdata[adcsq_pkg::ON_BIT];
            end
            if (!on_reg || done || (sleep_kill && running)) begin
                go_reg <= 1'b0;
            end else if (wr_c0) begin
                go_reg <= i_pwdata[adcsq_pkg::GO_BIT];
            end
            if (wr_c1) begin
                align_reg <= i_pwdata[adcsq_pkg::ALIGN_BIT];
                halve_reg <= i_pwdata[adcsq_pkg::HALVE_BIT];
                pcfg_reg  <= i_pwdata[3:0];
            end
            if (wr_dr) begin
                dir_reg <= i_pwdata[4:0];
            end
        end
    end

    // Done flag: set wins over a write-one clear; wake pulse in sleep
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            done_flag_reg <= 1'b0;
            wake_reg      <= 1'b0;
        end else begin
            done_flag_reg <= done | (done_flag_reg & ~(wr_st & i_pwdata[adcsq_pkg::STAT_DONE_BIT]));
            wake_reg      <= done & i_sleep & i_conv_int_en;
        end
    end

    // Result pair holds no reset; abort never reaches it
    always_ff @(posedge i_clk) begin
        if (done) begin
            res_hi_reg <= just_hi;
            res_lo_reg <= just_lo;
        end else begin
            if (wr_rh) begin
                res_hi_reg <= i_pwdata[7:0];
            end
            if (wr_rl) begin
                res_lo_reg <= i_pwdata[7:0];
            end
        end
    end

    // Port pins resynchronised, level taken when stages agree
    always_ff @(posedge i_clk) begin
        pin_s1_reg <= i_port_pins;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        if (!i_rstn) begin
            pin_lvl_reg <= 5'h00;
        end else begin
            pin_lvl_reg <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                         | (pin_lvl_reg & (pin_s2_reg ^ pin_s3_reg));
        end
    end

    // Read mux
    wire [4:0] analog  = analog_of(pcfg_reg);
    wire [7:0] rd_c0   = {src_pair_reg, chan_reg, go_reg, 1'b0, on_reg};
    wire [7:0] rd_c1   = {align_reg, halve_reg, 2'h0, pcfg_reg};
    wire [7:0] rd_st   = {state_reg, powered, running, done_flag_reg};
    wire [7:0] rd_pt   = {3'h0, pin_lvl_reg & ~analog};
    wire [7:0] rd_byte = hit_c0 ? rd_c0 : hit_c1 ? rd_c1 : hit_rh ? res_hi_reg
                       : hit_rl ? res_lo_reg : hit_st ? rd_st : hit_pt ? rd_pt
                       : hit_dr ? {3'h0, dir_reg} : 8'h00;

    // Bus answer: no wait states, error on unmapped address
    assign o_prdata  = {24'h000000, rd_byte};
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;

    // Analog front end; pin direction never gates a conversion
    assign o_conv_done_flag = done_flag_reg;
    assign o_wake           = wake_reg;
    assign o_adc_power      = powered;
    assign o_hold_connect   = st_idle;
    assign o_sar_code       = sar_reg;
    assign o_channel_select = chan_reg;
    assign o_analog_mask    = analog;
    assign o_port_dir       = dir_reg;
    assign o_busy           = running;

    // Helper: ticks seen while converting
    always_ff @(posedge i_clk) begin
        if (!i_rstn || !st_conv) begin
            conv_ticks_reg <= 4'h0;
        end else if (decide) begin
            conv_ticks_reg <= conv_ticks_reg + 4'h1;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_rc_go;
        rc_sel && powered && $rose(st_first);
    endsequence

    sequence s_first_len;
        st_first [*4];
    endsequence

    a_conv_nine_tads: assert property (done |-> conv_ticks_reg == adcsq_pkg::CONV_TADS - 4'h1)
        else $error("Conversion did not take nine bit-periods");
    a_hold_after_done: assert property (done && powered |=> st_hold && !o_hold_connect ##1 st_hold)
        else $error("No hold-off after conversion");
    a_abort_keeps_res: assert property (abort |=> $stable(res_hi_reg) && $stable(res_lo_reg) ##1 st_hold)
        else $error("Abort changed the result pair");
    a_first_bounded: assert property (!rc_sel && $rose(st_first) |-> ##[1:66] !st_first)
        else $error("First segment longer than a bit-period");
    a_rc_tcy_wait: assert property (s_rc_go |-> s_first_len)
        else $error("RC start did not wait an instruction cycle");
    a_done_clears_go: assert property (done |=> !go_reg && done_flag_reg && !st_conv)
        else $error("Completion did not clear go and set flag");
    a_align_zero_fill: assert property (done |=> ($past(align_reg) ? res_hi_reg[7:2] == 6'h00
                                                   : res_lo_reg[5:0] == 6'h00))
        else $error("Unused result bits not zero");
    a_sleep_power_off: assert property (on_reg && sleep_kill |-> !o_adc_power ##1 st_off && on_reg)
        else $error("Sleep did not power down the converter");
    a_port_analog_zero: assert property (hit_pt |-> (o_prdata[4:0] & analog) == 5'h00)
        else $error("Analog pin read as nonzero");
endmodule : adcsq_top

// File: rtl/adcsq_pkg.sv
// Shared constants and types for the conversion sequencer.
// Assumes an APB master on an 8-bit byte address, 32-bit data.
package adcsq_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL0  = 8'h00;
    localparam logic [7:0] ADDR_CTRL1  = 8'h04;
    localparam logic [7:0] ADDR_RES_HI = 8'h08;
    localparam logic [7:0] ADDR_RES_LO = 8'h0c;
    localparam logic [7:0] ADDR_STAT   = 8'h10;
    localparam logic [7:0] ADDR_PORT   = 8'h14;
    localparam logic [7:0] ADDR_DIR    = 8'h18;
    // Control 0 fields
    localparam int SRC_LSB = 6;
    localparam int CHAN_LSB = 3;
    localparam int GO_BIT = 2;
    localparam int ON_BIT = 0;
    // Control 1 fields and status done bit
    localparam int ALIGN_BIT = 7;
    localparam int HALVE_BIT = 6;
    localparam int STAT_DONE_BIT = 0;
    // Reset values and RC clock pair code
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [4:0] DIR_RST   = 5'h1f;
    localparam logic [1:0] RC_PAIR   = 2'h3;
    // Timing: instruction cycle in oscillator periods
    localparam int TCY_OSC = 4;
    localparam int TCY_CYCLES = TCY_OSC * 1;
    localparam logic [2:0] TCY_LAST = 3'(TCY_CYCLES - 1);
    localparam logic [3:0] CONV_TADS = 4'h9;
    localparam logic [2:0] HOLD_LAST = 3'h1;
    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_IDLE  = 5'h02,
        ST_FIRST = 5'h04,
        ST_CONV  = 5'h08,
        ST_HOLD  = 5'h10
    } adcsq_state_t;
endpackage : adcsq_pkg

// File: rtl/adcsq_tad_if.sv
// Bit-period request and tick between sequencer and clock generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface adcsq_tad_if;
    logic       restart;
    logic [1:0] pair;
    logic       halve;
    logic       tick;
    modport gen (input restart, input pair, input halve, output tick);
    modport seq (output restart, output pair, output halve, input tick);
endinterface : adcsq_tad_if

// File: rtl/adcsq_tad_gen.sv
// Bit-period tick generator: divided oscillator or resynchronised RC.
// Assumes i_rc_osc is asynchronous to i_clk.
`timescale 1ns/1ps
module adcsq_tad_gen (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_rc_osc,
    adcsq_tad_if.gen  tad
);
    logic       rc_s1_reg;
    logic       rc_s2_reg;
    logic       rc_s3_reg;
    logic       rc_lvl_reg;
    logic [5:0] div_cnt_reg;
    logic [5:0] div_last;
    logic       div_tick;
    logic       rc_rise;
    logic       rc_sel;

    // Period minus one: 2 << {pair, halve}
    assign div_last = 6'((7'h02 << {tad.pair, tad.halve}) - 7'h01);
    assign div_tick = (div_cnt_reg == div_last);
    assign rc_sel   = (tad.pair == adcsq_pkg::RC_PAIR);
    assign rc_rise  = (rc_s2_reg == rc_s3_reg) & rc_s2_reg & ~rc_lvl_reg;
    assign tad.tick = rc_sel ? rc_rise : (div_tick & ~tad.restart);

    // RC clock resync, level accepted when stages two and three agree
    always_ff @(posedge i_clk) begin
        rc_s1_reg <= i_rc_osc;
        rc_s2_reg <= rc_s1_reg;
        rc_s3_reg <= rc_s2_reg;
        if (!i_rstn) begin
            rc_lvl_reg <= 1'b0;
        end else if (rc_s2_reg == rc_s3_reg) begin
            rc_lvl_reg <= rc_s2_reg;
        end
    end

    // Divider restarts at conversion start so periods align
    always_ff @(posedge i_clk) begin
        if (!i_rstn || tad.restart || div_tick) begin
            div_cnt_reg <= 6'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end
endmodule : adcsq_tad_gen

// File: tb/adcsq_afe_model.sv
// Analog front end model: hold capacitor switch and comparator.
// Assumes the sequencer drives trial code and hold switch on i_clk.
`timescale 1ns/1ps
module adcsq_afe_model (
    input  wire logic       i_clk,
    input  wire logic       i_hold_connect,
    input  wire logic [9:0] i_level,
    input  wire logic [9:0] i_sar_code,
    output logic            o_cmp_hi
);
    logic [9:0] held_reg = 10'h000;

    // Track the pin only while the switch is closed; charge is kept otherwise
    always @(posedge i_clk) begin
        if (i_hold_connect) begin
            held_reg <= i_level;
        end
    end

    // Comparator: high when the held level reaches the trial code
    assign o_cmp_hi = (held_reg >= i_sar_code);
endmodule : adcsq_afe_model

// File: tb/tb_adc_conversion_sequencer.sv
// Self-checking bench for the conversion sequencer top.
// Assumes APB with no wait states forced and an RC clock made here.
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
    localparam int ACQ = 500; // About 20 us of settling after a channel change
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pw = 1'b0;
    logic        rc = 1'b0;
    logic        run_rc = 1'b0;
    logic        slp = 1'b0;
    logic        ien = 1'b0;
    logic        se;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic [31:0] q;
    logic        rdy, serr, cmp, done, wake, apw, hold, busy;
    logic [9:0]  sar;
    logic [9:0]  lvl = 10'h000;
    logic [7:0]  last_hi, last_lo;
    logic [2:0]  chan;
    logic [4:0]  pins = 5'h00;
    logic [4:0]  amask, pdir;
    logic [9:0]  codes [6] = '{10'h2b7, 10'h155, 10'h3ff, 10'h000, 10'h201, 10'h0cd};
    int          bad_count = 0;
    int          n_tests = 0;

    // Device and analog front end
    adcsq_top dut_u (
        .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
        .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(serr),
        .i_rc_osc(rc), .i_sleep(slp), .i_conv_int_en(ien), .i_cmp_hi(cmp), .i_port_pins(pins),
        .o_conv_done_flag(done), .o_wake(wake), .o_adc_power(apw), .o_hold_connect(hold),
        .o_sar_code(sar), .o_channel_select(chan), .o_analog_mask(amask), .o_port_dir(pdir),
        .o_busy(busy)
    );
    adcsq_afe_model afe_u (
        .i_clk(clk), .i_hold_connect(hold), .i_level(lvl), .i_sar_code(sar), .o_cmp_hi(cmp)
    );

    // System clock and a free RC clock of about 4 us, unrelated in phase
    always #20 clk = ~clk;
    always #2001 rc = run_rc ? ~rc : 1'b0;

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Wait for a design output to go high, counting edges
    task automatic wfor(ref logic s, output int k);
        k = 0;
        while (s !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
    endtask : wfor

    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pw <= w;
        padr <= a;
        pwd <= d;
        pen <= 1'b0;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        se = serr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask : rchk

    // Configure, switch on, acquire, clear the flag, then set go
    task automatic start(input logic [7:0] c1, input logic [7:0] c0);
        apb(1'b1, adcsq_pkg::ADDR_CTRL1, {24'h0, c1});
        apb(1'b1, adcsq_pkg::ADDR_CTRL0, {24'h0, c0});
        cyc(ACQ);
        apb(1'b1, adcsq_pkg::ADDR_STAT, 32'h1);
        apb(1'b1, adcsq_pkg::ADDR_CTRL0, {24'h0, c0 | 8'h04});
    endtask : start

    task automatic t_gp();
        apb(1'b1, adcsq_pkg::ADDR_RES_HI, 32'ha5);
        apb(1'b1, adcsq_pkg::ADDR_RES_LO, 32'h3c);
        last_hi = 8'ha5;
        last_lo = 8'h3c;
        rchk(adcsq_pkg::ADDR_RES_HI, 32'ha5, "gp high");
        rchk(adcsq_pkg::ADDR_RES_LO, 32'h3c, "gp low");
        apb(1'b1, adcsq_pkg::ADDR_CTRL0, 32'h05);
        rchk(adcsq_pkg::ADDR_CTRL0, 32'h01, "go with on");
        chk("busy after on", 32'(busy), 32'h0);
        rchk(8'h1c, 32'h0, "unmapped data");
        chk("unmapped err", 32'(se), 32'h1);
        $display("general purpose bytes done");
    endtask : t_gp

    task automatic t_reset();
        start(8'h80, 8'h01);
        cyc(7);
        rstn <= 1'b0;
        cyc(20);
        rstn <= 1'b1;
        chk("busy", 32'(busy), 32'h0);
        chk("power", 32'(apw), 32'h0);
        chk("analog mask", 32'(amask), 32'h1f);
        chk("direction", 32'(pdir), 32'h1f);
        rchk(adcsq_pkg::ADDR_CTRL0, 32'h0, "ctrl0");
        rchk(adcsq_pkg::ADDR_CTRL1, 32'h0, "ctrl1");
        rchk(adcsq_pkg::ADDR_STAT, 32'h08, "status");
        rchk(adcsq_pkg::ADDR_RES_HI, {24'h0, last_hi}, "kept high");
        rchk(adcsq_pkg::ADDR_RES_LO, {24'h0, last_lo}, "kept low");
        $display("reset done");
    endtask : t_reset

    // Digital pins read back, analog pins read zero; pins left as outputs
    task automatic t_port();
        pins <= 5'h15;
        apb(1'b1, adcsq_pkg::ADDR_CTRL1, 32'h06);
        cyc(6);
        rchk(adcsq_pkg::ADDR_PORT, 32'h15, "port digital");
        chk("mask digital", 32'(amask), 32'h0);
        apb(1'b1, adcsq_pkg::ADDR_CTRL1, 32'h0e);
        rchk(adcsq_pkg::ADDR_PORT, 32'h14, "port mixed");
        chk("mask mixed", 32'(amask), 32'h01);
        apb(1'b1, adcsq_pkg::ADDR_CTRL1, 32'h04);
        rchk(adcsq_pkg::ADDR_PORT, 32'h14, "port cfg4");
        chk("mask cfg4", 32'(amask), 32'h0b);
        apb(1'b1, adcsq_pkg::ADDR_CTRL1, 32'h0f);
        rchk(adcsq_pkg::ADDR_PORT, 32'h10, "port cfgf");
        chk("mask cfgf", 32'(amask), 32'h0d);
        apb(1'b1, adcsq_pkg::ADDR_DIR, 32'h0);
        rchk(adcsq_pkg::ADDR_DIR, 32'h0, "direction");
        $display("port done");
    endtask : t_port

    // One conversion per divider setting; only divide by 64 is in the legal window here
    task automatic run_conv(input logic [2:0] sel, input logic [9:0] code);
        int n;
        int k;
        n = 2 << sel;
        lvl <= code;
        start({sel[0], sel[0], 6'h00}, {sel[2:1], 6'h11});
        wfor(done, k);
        chk("conv time", 32'(k >= 10 * n && k <= 10 * n + 4), 32'h1);
        chk("hold at end", 32'(hold), 32'h0);
        wfor(hold, k);
        chk("hold off", 32'(k >= 2 * n - 2 && k <= 2 * n + 2), 32'h1);
        last_hi = sel[0] ? {6'h00, code[9:8]} : code[9:2];
        last_lo = sel[0] ? code[7:0] : {code[1:0], 6'h00};
        rchk(adcsq_pkg::ADDR_RES_HI, {24'h0, last_hi}, "result high");
        rchk(adcsq_pkg::ADDR_RES_LO, {24'h0, last_lo}, "result low");
        rchk(adcsq_pkg::ADDR_CTRL0, {24'h0, sel[2:1], 6'h11}, "go cleared");
        rchk(adcsq_pkg::ADDR_STAT, 32'h15, "done flag");
        chk("channel", 32'(chan), 32'h2);
        $display("conversion %0d done", sel);
    endtask : run_conv

    task automatic t_abort();
        int k;
        lvl <= 10'h0f0;
        start(8'hc0, 8'h91);
        cyc(200);
        apb(1'b1, adcsq_pkg::ADDR_CTRL0, 32'h91);
        cyc(2);
        chk("abort busy", 32'(busy), 32'h0);
        wfor(hold, k);
        chk("abort wait", 32'(k >= 62 && k <= 130), 32'h1);
        chk("abort flag", 32'(done), 32'h0);
        rchk(adcsq_pkg::ADDR_RES_HI, {24'h0, last_hi}, "abort high");
        rchk(adcsq_pkg::ADDR_RES_LO, {24'h0, last_lo}, "abort low");
        $display("abort done");
    endtask : t_abort

    task automatic t_sleep();
        start(8'h00, 8'h51);
        cyc(30);
        slp <= 1'b1;
        cyc(3);
        chk("sleep power", 32'(apw), 32'h0);
        chk("sleep busy", 32'(busy), 32'h0);
        rchk(adcsq_pkg::ADDR_CTRL0, 32'h51, "sleep on kept");
        slp <= 1'b0;
        rchk(adcsq_pkg::ADDR_RES_HI, {24'h0, last_hi}, "sleep high");
        $display("sleep abort done");
    endtask : t_sleep

    // RC clock conversion with sleep entered right after go
    task automatic t_rc();
        int k;
        run_rc = 1'b1;
        ien <= 1'b1;
        lvl <= 10'h1e3;
        start(8'h80, 8'hd1);
        slp <= 1'b1;
        wfor(wake, k);
        chk("rc time", 32'(k >= 880 && k <= 1130), 32'h1);
        chk("wake", 32'(wake), 32'h1);
        chk("rc power", 32'(apw), 32'h1);
        slp <= 1'b0;
        rchk(adcsq_pkg::ADDR_CTRL0, 32'hd1, "rc go cleared");
        rchk(adcsq_pkg::ADDR_RES_HI, 32'h01, "rc high");
        rchk(adcsq_pkg::ADDR_RES_LO, 32'he3, "rc low");
        run_rc = 1'b0;
        $display("rc sleep done");
    endtask : t_rc

    // Main sequence
    initial begin
        cyc(20);
        rstn <= 1'b1;
        t_gp();
        t_reset();
        t_port();
        for (int i = 0; i < 6; i++) begin
            run_conv(3'(i), codes[i]);
        end
        t_abort();
        t_sleep();
        t_rc();
        print_verdict();
    end

    // Watchdog against a hang
    initial begin
        cyc(40000);
        bad_count++;
        print_verdict();
    end
endmodule : tb_adc_conversion_sequencer
